/* hdl/pixel_serializer_28to4.sv */
// 28-bit pixel word capture and four-lane seven-slot serializer
// Notes on behaviour
// - slot 0 sends pixel bits 1, 9, 20, 5 on lanes 0 to 3.
// - slot 1 sends pixel bits 0, 8, 19, 27 on lanes 0 to 3.
// - slot 2 sends pixel bits 7, 18, 26, 23 on lanes 0 to 3.
// - slot 3 sends pixel bits 6, 15, 25, 17 on lanes 0 to 3.
// - slot 4 sends pixel bits 4, 14, 24, 16 on lanes 0 to 3.
// - slot 5 sends pixel bits 3, 13, 22, 11 on lanes 0 to 3.
// - slot 6 sends pixel bits 2, 12, 21, 10 on lanes 0 to 3.
// - link clock is high four slots and low three slots.
// - lanes become valid about six microseconds after power-down release.
// - power-down low floats the link clock output about five system clock cycles (50 ns) later.
// - all 28 bits are captured together on the selected pixel clock edge.
// - each lane carries seven bits per link clock period.
module pixel_serializer_28to4
	import pixser_pkg::*;
(
	input  wire logic              i_clk,                  // system clock
	input  wire logic              i_arst_n,               // async reset, low
	input  wire logic              i_link_bit_clk,         // 7x link clock
	input  wire logic              i_pixel_clock_in,       // pixel clock pin
	input  wire logic              i_capture_edge_select,  // 1 rise, 0 fall
	input  wire logic              i_power_down_n,         // shutdown, low
	input  wire logic [WORD_W-1:0] i_pixel_word_bits,      // pixel word pins
	output logic                   o_link_clock_out,       // forwarded clock
	output logic                   o_link_clock_oe,        // clock drive on
	output logic      [LANE_N-1:0] o_serial_lane_out,      // serial lanes
	output logic                   o_serial_lane_oe,       // lane drive on
	output logic                   o_word_ready,           // buffer has room
	output logic                   o_overrun               // word dropped
);

	// pin sampling, system clock side
	pin_sample_type pin_q;
	logic           pclk_prev_r;

	// power and lock state
	logic [LOCK_CNT_W-1:0] lock_cnt_r;
	logic [LOCK_CNT_W-1:0] lock_cnt_nxt;
	logic                  locked_r;
	logic                  locked_nxt;
	logic                  oe_r;
	logic                  oe_nxt;
	logic                  overrun_r;
	logic                  overrun_nxt;
	logic                  word_ready_r;

	// buffer and hand-over
	logic           fifo_in_ready;
	logic           fifo_out_valid;
	pixel_word_type fifo_out_data;
	xfer_state_type xfer_state_r;
	xfer_state_type xfer_state_nxt;
	pixel_word_type hold_r;
	logic           req_r;
	logic           ack_q;

	// link clock side
	logic           en_q;
	logic           req_q;
	logic           en_r;
	slot_type       slot_r;
	slot_type       slot_nxt;
	pixel_word_type cur_word_r;
	pixel_word_type word_nxt;
	logic           ack_r;
	link_out_type   link_out_r;
	link_out_type   link_out_nxt;
	logic [LANE_N-1:0] lane_bits;
	logic [1:0]        link_q;

	// all pins pass three flops; power-down reads as asserted at reset
	sync3 #(
		.WIDTH (PIN_W),
		.INIT  ('0)
	) pin_sync (
		.i_clk    (i_clk),
		.i_arst_n (i_arst_n),
		.i_d      ({i_pixel_clock_in, i_capture_edge_select,
		            i_power_down_n, i_pixel_word_bits}),
		.o_q      (pin_q)
	);

	// acknowledge toggle back from the link domain
	sync3 #(
		.WIDTH (1),
		.INIT  (1'b0)
	) ack_sync (
		.i_clk    (i_clk),
		.i_arst_n (i_arst_n),
		.i_d      (ack_r),
		.o_q      (ack_q)
	);

	// capture edge: data and clock share the same sampling delay
	wire pclk_rise = pin_q.pclk & ~pclk_prev_r;
	wire pclk_fall = ~pin_q.pclk & pclk_prev_r;
	wire cap_edge  = pin_q.edge_sel ? pclk_rise : pclk_fall;
	// words are taken only once locked, never while powered down
	wire cap_valid = cap_edge & locked_r & pin_q.pd_n;

	// lock timer restarts on every power-down
	assign lock_cnt_nxt = !pin_q.pd_n ? LOCK_CNT_RST :
		(locked_r ? lock_cnt_r : LOCK_CNT_W'(lock_cnt_r + 1'b1));
	assign locked_nxt   = pin_q.pd_n &
		(locked_r | (lock_cnt_r == LOCK_CNT_MAX));
	// drive enable drops in the first cycle power-down is seen
	assign oe_nxt       = pin_q.pd_n & locked_nxt;
	// a word that finds the buffer full is lost and flagged
	assign overrun_nxt  = cap_valid & ~fifo_in_ready;

	// pin edge history and lock timer
	always_ff @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			pclk_prev_r <= 1'b0;
			lock_cnt_r  <= LOCK_CNT_RST;
			locked_r    <= 1'b0;
		end else begin
			pclk_prev_r <= pin_q.pclk;
			lock_cnt_r  <= lock_cnt_nxt;
			locked_r    <= locked_nxt;
		end
	end

	// registered status and drive enables
	always_ff @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			oe_r         <= 1'b0;
			overrun_r    <= 1'b0;
			word_ready_r <= 1'b0;
		end else begin
			oe_r         <= oe_nxt;
			overrun_r    <= overrun_nxt;
			word_ready_r <= fifo_in_ready & locked_r;
		end
	end

	// two words of slack absorb the hand-over latency to the link side
	word_fifo #(
		.WIDTH (WORD_W),
		.DEPTH (BUF_DEPTH)
	) word_buf (
		.i_clk    (i_clk),
		.i_arst_n (i_arst_n),
		.i_flush  (~pin_q.pd_n),
		.i_valid  (cap_valid),
		.o_ready  (fifo_in_ready),
		.i_data   (pin_q.bits),
		.o_valid  (fifo_out_valid),
		.i_ready  (xfer_state_r == XFER_IDLE),
		.o_data   (fifo_out_data)
	);

	// toggle handshake: the held word stays put until the toggle returns
	wire xfer_start = (xfer_state_r == XFER_IDLE) & fifo_out_valid;
	wire xfer_done  = (xfer_state_r == XFER_WAIT) & (ack_q == req_r);

	always_comb begin
		xfer_state_nxt = xfer_state_r;
		case (xfer_state_r)
			XFER_IDLE: begin
				if (xfer_start) xfer_state_nxt = XFER_WAIT;
			end
			XFER_WAIT: begin
				if (xfer_done) xfer_state_nxt = XFER_IDLE;
			end
			default: xfer_state_nxt = XFER_IDLE;
		endcase
	end

	// hand-over registers
	always_ff @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			xfer_state_r <= XFER_IDLE;
			hold_r       <= '0;
			req_r        <= 1'b0;
		end else begin
			xfer_state_r <= xfer_state_nxt;
			if (xfer_start) begin
				hold_r <= fifo_out_data;
				req_r  <= ~req_r;
			end
		end
	end

	// enable level and request toggle into the link domain
	sync3 #(
		.WIDTH (2),
		.INIT  (2'h0)
	) link_sync (
		.i_clk    (i_link_bit_clk),
		.i_arst_n (i_arst_n),
		.i_d      ({locked_r, req_r}),
		.o_q      (link_q)
	);

	// unpack the synchronised pair
	assign en_q  = link_q[1];
	assign req_q = link_q[0];

	// a new word is only picked up at the period boundary
	wire period_end = (slot_r == LAST_SLOT);
	wire take       = period_end & (req_q != ack_r);

	// slot counter wraps every seven bit clocks
	assign slot_nxt = !en_q ? LAST_SLOT :
		(period_end ? FIRST_SLOT : SLOT_W'(slot_r + 1'b1));
	// without a fresh word the last one is repeated, one word per period
	assign word_nxt = !en_q ? '0 :
		(take ? hold_r : cur_word_r);

	// each lane picks its bit for the coming slot from the map
	for (genvar l = 0; l < LANE_N; l++) begin : g_lane
		assign lane_bits[l] = word_nxt[LANE_MAP[slot_nxt][l]];
	end

	// clock high in slots 0 to 3, all quiet while disabled
	assign link_out_nxt.lane = en_q ? lane_bits : '0;
	assign link_out_nxt.clk  = en_q & (slot_nxt < HIGH_SLOTS);

	// link-side state; acks continue while disabled so no word hangs
	always_ff @(posedge i_link_bit_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			slot_r     <= LAST_SLOT;
			cur_word_r <= '0;
			ack_r      <= 1'b0;
			en_r       <= 1'b0;
			link_out_r <= LINK_IDLE;
		end else begin
			slot_r     <= slot_nxt;
			cur_word_r <= word_nxt;
			en_r       <= en_q;
			link_out_r <= link_out_nxt;
			if (take) ack_r <= req_q;
		end
	end

	// outputs come straight from their flops
	assign o_link_clock_out  = link_out_r.clk;
	assign o_serial_lane_out = link_out_r.lane;
	assign o_link_clock_oe   = oe_r;
	assign o_serial_lane_oe  = oe_r;
	assign o_word_ready      = word_ready_r;
	assign o_overrun         = overrun_r;

	// slot contents against the word being sent
	chk_slot_zero: assert property (@(posedge i_link_bit_clk)
		disable iff (!i_arst_n) (en_r && slot_r == 3'h0) |->
		o_serial_lane_out == {cur_word_r[5], cur_word_r[20],
		                      cur_word_r[9], cur_word_r[1]})
		else $error("slot 0 lane bits wrong");
	chk_slot_one: assert property (@(posedge i_link_bit_clk)
		disable iff (!i_arst_n) (en_r && slot_r == 3'h1) |->
		o_serial_lane_out == {cur_word_r[27], cur_word_r[19],
		                      cur_word_r[8], cur_word_r[0]})
		else $error("slot 1 lane bits wrong");
	chk_slot_two: assert property (@(posedge i_link_bit_clk)
		disable iff (!i_arst_n) (en_r && slot_r == 3'h2) |->
		o_serial_lane_out == {cur_word_r[23], cur_word_r[26],
		                      cur_word_r[18], cur_word_r[7]})
		else $error("slot 2 lane bits wrong");
	chk_slot_three: assert property (@(posedge i_link_bit_clk)
		disable iff (!i_arst_n) (en_r && slot_r == 3'h3) |->
		o_serial_lane_out == {cur_word_r[17], cur_word_r[25],
		                      cur_word_r[15], cur_word_r[6]})
		else $error("slot 3 lane bits wrong");
	chk_slot_four: assert property (@(posedge i_link_bit_clk)
		disable iff (!i_arst_n) (en_r && slot_r == 3'h4) |->
		o_serial_lane_out == {cur_word_r[16], cur_word_r[24],
		                      cur_word_r[14], cur_word_r[4]})
		else $error("slot 4 lane bits wrong");
	chk_slot_five: assert property (@(posedge i_link_bit_clk)
		disable iff (!i_arst_n) (en_r && slot_r == 3'h5) |->
		o_serial_lane_out == {cur_word_r[11], cur_word_r[22],
		                      cur_word_r[13], cur_word_r[3]})
		else $error("slot 5 lane bits wrong");
	chk_slot_six: assert property (@(posedge i_link_bit_clk)
		disable iff (!i_arst_n) (en_r && slot_r == 3'h6) |->
		o_serial_lane_out == {cur_word_r[10], cur_word_r[21],
		                      cur_word_r[12], cur_word_r[2]})
		else $error("slot 6 lane bits wrong");

	// clock shape and period; a period cut by power-down is excused
	chk_clock_duty: assert property (@(posedge i_link_bit_clk)
		disable iff (!i_arst_n || !en_q) $rose(o_link_clock_out) |->
		o_link_clock_out [*4] ##1 !o_link_clock_out [*3])
		else $error("link clock not four high three low");
	chk_clock_period: assert property (@(posedge i_link_bit_clk)
		disable iff (!i_arst_n)
		($rose(o_link_clock_out) ##1 en_q [*6]) |->
		##1 $rose(o_link_clock_out))
		else $error("link clock period not seven slots");

	// word stays whole within one period
	chk_word_whole: assert property (@(posedge i_link_bit_clk)
		disable iff (!i_arst_n) (en_r && slot_r != FIRST_SLOT) |->
		$stable(cur_word_r))
		else $error("word changed inside a period");

	// disabled link is silent
	chk_link_quiet: assert property (@(posedge i_link_bit_clk)
		disable iff (!i_arst_n) !en_r |->
		(o_serial_lane_out == '0 && !o_link_clock_out))
		else $error("link active while disabled");

	// drive enable follows power-down within one cycle
	chk_float_fast: assert property (@(posedge i_clk)
		disable iff (!i_arst_n) !pin_q.pd_n |=> !o_link_clock_oe)
		else $error("clock still driven after power-down");

	// lock needs the full count of powered cycles
	chk_lock_wait: assert property (@(posedge i_clk)
		disable iff (!i_arst_n) $rose(locked_r) |->
		($past(lock_cnt_r) == LOCK_CNT_MAX && $past(pin_q.pd_n)))
		else $error("lock reached before the lock time");

	// with the falling edge selected, a captured word enters the buffer on that edge only
	chk_capture_edge: assert property (@(posedge i_clk)
		disable iff (!i_arst_n) (cap_valid && !pin_q.edge_sel) |->
		(!pin_q.pclk && pclk_prev_r))
		else $error("capture on the wrong pixel clock edge");

	// lanes float together with the forwarded clock
	chk_lane_float: assert property (@(posedge i_clk)
		disable iff (!i_arst_n) !pin_q.pd_n |=> !o_serial_lane_oe)
		else $error("lanes still driven after power-down");

	// the pin side stops offering room two cycles into power-down
	chk_ready_down: assert property (@(posedge i_clk)
		disable iff (!i_arst_n) !pin_q.pd_n |-> ##2 !o_word_ready)
		else $error("word ready while powered down");

	// buffered words are dropped at once, so stale pixels never go out
	chk_flush_down: assert property (@(posedge i_clk)
		disable iff (!i_arst_n) !pin_q.pd_n |=> !fifo_out_valid)
		else $error("buffer kept words over power-down");

	// slot counter never leaves its seven values
	chk_slot_range: assert property (@(posedge i_link_bit_clk)
		disable iff (!i_arst_n) slot_r <= LAST_SLOT)
		else $error("slot counter out of range");

	// a period only starts where the previous one ended
	chk_period_start: assert property (@(posedge i_link_bit_clk)
		disable iff (!i_arst_n) (en_r && slot_r == FIRST_SLOT) |->
		$past(slot_r) == LAST_SLOT)
		else $error("period started mid-way");

endmodule

/* hdl/pixser_pkg.sv */
// shared constants, types and the lane map of the 28-to-4 pixel serializer
package pixser_pkg;

	// word and lane geometry
	localparam int WORD_W     = 28;
	localparam int LANE_N     = 4;
	localparam int SLOT_N     = 7;
	localparam int SLOT_W     = 3;
	localparam int BIT_IDX_W  = 5;

	typedef logic [SLOT_W-1:0]    slot_type;
	typedef logic [BIT_IDX_W-1:0] bit_index_type;
	typedef logic [WORD_W-1:0]    pixel_word_type;

	// slot numbers of one link clock period
	localparam slot_type FIRST_SLOT = 3'h0;
	localparam slot_type LAST_SLOT  = 3'h6;
	// link clock stays high while slot is below this value
	localparam slot_type HIGH_SLOTS = 3'h4;

	// pixel bit carried by each lane in each slot, lane 0 first
	localparam bit_index_type LANE_MAP [SLOT_N][LANE_N] = '{
		'{5'h01, 5'h09, 5'h14, 5'h05},
		'{5'h00, 5'h08, 5'h13, 5'h1B},
		'{5'h07, 5'h12, 5'h1A, 5'h17},
		'{5'h06, 5'h0F, 5'h19, 5'h11},
		'{5'h04, 5'h0E, 5'h18, 5'h10},
		'{5'h03, 5'h0D, 5'h16, 5'h0B},
		'{5'h02, 5'h0C, 5'h15, 5'h0A}
	};

	// timing of the system clock and of power-up and shutdown
	localparam int CLK_MHZ      = 100;
	localparam int LOCK_TIME_NS = 6000;
	localparam int DIS_TIME_NS  = 7;
	// least time: round up
	localparam int LOCK_CYCLES  = (LOCK_TIME_NS * CLK_MHZ + 999) / 1000;
	// longest time: round down, never below one cycle
	localparam int DIS_RAW      = (DIS_TIME_NS * CLK_MHZ) / 1000;
	localparam int DIS_CYCLES   = (DIS_RAW < 1) ? 1 : DIS_RAW;
	localparam int LOCK_CNT_W   = 10;
	localparam logic [LOCK_CNT_W-1:0] LOCK_CNT_MAX =
		LOCK_CNT_W'(LOCK_CYCLES - 1);
	localparam logic [LOCK_CNT_W-1:0] LOCK_CNT_RST = 10'h000;

	// buffer depth in the word path
	localparam int BUF_DEPTH = 2;

	// pin inputs as sampled together
	typedef struct packed {
		logic           pclk;
		logic           edge_sel;
		logic           pd_n;
		pixel_word_type bits;
	} pin_sample_type;

	localparam int PIN_W = $bits(pin_sample_type);

	// one registered sample of the serial side
	typedef struct packed {
		logic [LANE_N-1:0] lane;
		logic              clk;
	} link_out_type;

	localparam link_out_type LINK_IDLE = 5'h00;

	// word hand-over towards the link domain
	typedef enum logic [0:0] {
		XFER_IDLE = 1'b0,
		XFER_WAIT = 1'b1
	} xfer_state_type;

endpackage

/* hdl/sync3.sv */
// three-stage synchroniser that passes a bit once stages two and three agree
module sync3 #(
	parameter int               WIDTH = 1,
	parameter logic [WIDTH-1:0] INIT  = '0
) (
	input  wire logic             i_clk,    // destination clock
	input  wire logic             i_arst_n, // async reset, low
	input  wire logic [WIDTH-1:0] i_d,      // foreign input
	output logic      [WIDTH-1:0] o_q       // filtered result
);
	logic [WIDTH-1:0] s1_r;
	logic [WIDTH-1:0] s2_r;
	logic [WIDTH-1:0] s3_r;
	wire  [WIDTH-1:0] agree = ~(s2_r ^ s3_r);

	// stage one feeds stage two only, so metastability stays contained
	always_ff @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			s1_r <= INIT;
			s2_r <= INIT;
			s3_r <= INIT;
			o_q  <= INIT;
		end else begin
			s1_r <= i_d;
			s2_r <= s1_r;
			s3_r <= s2_r;
			o_q  <= (s2_r & agree) | (o_q & ~agree);
		end
	end
endmodule

/* hdl/word_fifo.sv */
// small fifo with valid and ready on both sides and a flush input
module word_fifo #(
	parameter int WIDTH = 28,
	parameter int DEPTH = 2
) (
	input  wire logic             i_clk,    // clock
	input  wire logic             i_arst_n, // async reset, low
	input  wire logic             i_flush,  // drop all entries
	input  wire logic             i_valid,  // word offered
	output logic                  o_ready,  // room for a word
	input  wire logic [WIDTH-1:0] i_data,   // word in
	output logic                  o_valid,  // word available
	input  wire logic             i_ready,  // drain takes word
	output logic      [WIDTH-1:0] o_data    // oldest word
);
	// pointers wrap naturally, so depth must be a power of two
	localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0]    wr_ptr_r;
	logic [AW-1:0]    rd_ptr_r;
	logic [AW:0]      count_r;

	wire push = i_valid & o_ready;
	wire pop  = o_valid & i_ready;

	// honest full and empty straight from the count
	assign o_ready = (count_r != (AW+1)'(DEPTH));
	assign o_valid = (count_r != '0);
	assign o_data  = mem[rd_ptr_r];

	// storage carries no reset, only the pointers and the count do
	always_ff @(posedge i_clk) begin
		if (push) begin
			mem[wr_ptr_r] <= i_data;
		end
	end

	// pointer and count update, flush wins over traffic
	always_ff @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			wr_ptr_r <= '0;
			rd_ptr_r <= '0;
			count_r  <= '0;
		end else if (i_flush) begin
			wr_ptr_r <= '0;
			rd_ptr_r <= '0;
			count_r  <= '0;
		end else begin
			if (push) wr_ptr_r <= AW'(wr_ptr_r + 1'b1);
			if (pop)  rd_ptr_r <= AW'(rd_ptr_r + 1'b1);
			if (push && !pop) count_r <= (AW+1)'(count_r + 1'b1);
			if (pop && !push) count_r <= (AW+1)'(count_r - 1'b1);
		end
	end
endmodule

/* sim/lvds_rx_model.sv */
// behavioural receiver that rebuilds pixel words from the four lanes
module lvds_rx_model
	import pixser_pkg::*;
(
	input  wire logic              i_bit_clk, // link bit clock
	input  wire logic              i_lclk,    // forwarded link clock
	input  wire logic              i_lclk_oe, // clock driven
	input  wire logic [LANE_N-1:0] i_lane,    // serial lanes
	input  wire logic              i_lane_oe, // lanes driven
	output pixel_word_type         o_word,    // rebuilt word
	output logic                   o_strobe,  // word complete
	output int                     o_bad      // broken frames
);
	timeunit 1ns;
	timeprecision 1ps;

	// pixel bit carried by each lane in each slot, kept apart from the design
	localparam int MAP [SLOT_N][LANE_N] = '{
		'{1, 9, 20, 5},
		'{0, 8, 19, 27},
		'{7, 18, 26, 23},
		'{6, 15, 25, 17},
		'{4, 14, 24, 16},
		'{3, 13, 22, 11},
		'{2, 12, 21, 10}
	};

	int                slot = -1;
	logic              prev = 1'b0;
	logic [SLOT_N-1:0] ck;
	logic [LANE_N-1:0] sl [SLOT_N];

	initial begin
		o_bad = 0;
		o_strobe = 1'b0;
		o_word = '0;
	end

	// sample mid-slot, away from the edge that launches the lanes
	always @(negedge i_bit_clk) begin
		o_strobe <= 1'b0;
		if (!(i_lclk_oe && i_lane_oe)) begin
			slot = -1; // undriven lines carry nothing, frame lost
		end else begin
			if (i_lclk && !prev) begin
				if (slot >= 0 && slot != SLOT_N)
					o_bad++;
				slot = 0;
			end
			if (slot >= 0 && slot < SLOT_N) begin
				sl[slot] = i_lane;
				ck[slot] = i_lclk;
				slot++;
				if (slot == SLOT_N) begin
					if (ck !== 7'h0F)
						o_bad++;
					for (int s = 0; s < SLOT_N; s++) begin
						for (int l = 0; l < LANE_N; l++) begin
							o_word[MAP[s][l]] = sl[s][l];
						end
					end
					o_strobe <= 1'b1;
				end
			end else if (slot >= SLOT_N) begin
				slot++; // an overlong period is caught at the next rise
			end
		end
		prev = i_lclk;
	end
endmodule

/* sim/pixel_serializer_28to4_bench.sv */
// self-checking bench: random pixel words through the serializer and back
module pixel_serializer_28to4_bench;
	import pixser_pkg::*;
	timeunit 1ns;
	timeprecision 1ps;

`define CHK(nm, e, g) begin checks++; if ((e) !== (g)) begin \
	fail_count++; $display("Error %s expected %h seen %h", nm, e, g); \
	end end

	logic              clk, arst_n, bit_clk, pclk, sel, pd_n, link_run;
	logic              lclk, lclk_oe, lane_oe, ready, ovr, strobe;
	logic              ignore, ovr_seen;
	logic [LANE_N-1:0] lane;
	pixel_word_type    data, rx_word, last_seen, exp_w;
	int                rx_bad, n, fail_count, checks;
	int                seed = 32'hAAF3;
	pixel_word_type    expq [$];

	initial clk = 1'b0;
	always #5 clk = ~clk;

	// link bit clock, 6 ns, offset so its edges never meet the system clock
	initial begin
		bit_clk = 1'b0;
		#0.7;
		forever #3 if (link_run) bit_clk = ~bit_clk;
	end

	pixel_serializer_28to4 i_pixel_serializer_28to4 (
		.i_clk                 (clk),
		.i_arst_n              (arst_n),
		.i_link_bit_clk        (bit_clk),
		.i_pixel_clock_in      (pclk),
		.i_capture_edge_select (sel),
		.i_power_down_n        (pd_n),
		.i_pixel_word_bits     (data),
		.o_link_clock_out      (lclk),
		.o_link_clock_oe       (lclk_oe),
		.o_serial_lane_out     (lane),
		.o_serial_lane_oe      (lane_oe),
		.o_word_ready          (ready),
		.o_overrun             (ovr)
	);

	lvds_rx_model i_lvds_rx_model (
		.i_bit_clk (bit_clk),
		.i_lclk    (lclk),
		.i_lclk_oe (lclk_oe),
		.i_lane    (lane),
		.i_lane_oe (lane_oe),
		.o_word    (rx_word),
		.o_strobe  (strobe),
		.o_bad     (rx_bad)
	);

	always @(posedge clk) if (ovr === 1'b1) ovr_seen <= 1'b1;

	// a repeated word is the link idling; only new words take a note off
	always @(posedge strobe) begin
		if (rx_word !== last_seen && rx_word !== '0) begin
			last_seen = rx_word;
			if (!ignore) begin
				exp_w = (expq.size() > 0) ? expq.pop_front() : ~rx_word;
				`CHK("word", exp_w, rx_word)
			end
		end
	end

	task automatic conclude();
		if (fail_count == 0 && checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	// one pixel period: the word changes away from the capture edge;
	// slower than one full hand-over so the buffer never backs up
	task automatic pix(input logic keep);
		pixel_word_type w;
		w = pixel_word_type'($random(seed));
		@(posedge clk) #1;
		data = w;
		pclk = ~sel;
		if (keep) expq.push_back(w);
		repeat (7) @(posedge clk);
		#1 pclk = sel;
		repeat (7) @(posedge clk);
	endtask

	// lanes stay undriven until the lock count has run out
	task automatic lock_wait();
		n = 0;
		while (ready !== 1'b1 && n < 700) begin
			@(posedge clk) #1;
			n++;
			if (n == 300) `CHK("early oe", 1'b0, lane_oe)
		end
		`CHK("lock", 1'b1, n >= LOCK_CYCLES && n < LOCK_CYCLES + 12)
		if (n >= 700) conclude();
	endtask

	task automatic drain();
		n = 0;
		while (expq.size() > 0 && n < 400) begin
			@(posedge clk);
			n++;
		end
		`CHK("left over", 0, expq.size())
		if (n >= 400) conclude();
	endtask

	initial begin
		{arst_n, pclk, ovr_seen, ignore} = 4'h0;
		{sel, pd_n, link_run} = 3'h7;
		data = '0;
		last_seen = '0;
		fail_count = 0;
		checks = 0;
		repeat (6) @(posedge clk);
		#1 arst_n = 1'b1;
		lock_wait();
		repeat (20) pix(1'b1);
		drain();
		// shutdown floats the outputs and ignores the pins meanwhile
		ignore = 1'b1;
		@(posedge clk) #1 pd_n = 1'b0;
		n = 0;
		while (lclk_oe !== 1'b0 && n < 20) begin
			@(posedge clk) #1;
			n++;
		end
		`CHK("float time", 1'b1, n <= 6)
		if (n >= 20) conclude();
		pix(1'b0);
		pix(1'b0);
		`CHK("idle", 6'h00, {lane, lclk, lane_oe})
		// come back capturing on the falling edge instead
		@(posedge clk) #1;
		sel = 1'b0;
		pclk = 1'b1;
		pd_n = 1'b1;
		lock_wait();
		ignore = 1'b0;
		repeat (20) pix(1'b1);
		drain();
		// stalled link: the two-entry buffer fills, further words are lost
		ignore = 1'b1;
		link_run = 1'b0;
		repeat (6) pix(1'b0);
		`CHK("ready full", 1'b0, ready)
		`CHK("overrun", 1'b1, ovr_seen)
		link_run = 1'b1;
		repeat (100) @(posedge clk);
		ignore = 1'b0;
		repeat (10) pix(1'b1);
		drain();
		`CHK("frames", 0, rx_bad)
		conclude();
	end

	// a hang anywhere ends the run as a mismatch
	initial begin
		#500us;
		fail_count++;
		conclude();
	end
endmodule
